// *** hw/mpfu_pkg.sv ***
package mpfu_pkg;

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_OP = 8'h00;
	localparam logic [7:0] ADDR_OPA = 8'h04;
	localparam logic [7:0] ADDR_OPB = 8'h08;
	localparam logic [7:0] ADDR_OFFS = 8'h0C;
	localparam logic [7:0] ADDR_PTRZ = 8'h10;
	localparam logic [7:0] ADDR_PC = 8'h14;
	localparam logic [7:0] ADDR_FLAGS = 8'h18;
	localparam logic [7:0] ADDR_PROD = 8'h1C;
	localparam logic [7:0] ADDR_STAT = 8'h20;
	localparam logic [7:0] ADDR_DEPTH = 8'h24;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int OP_BIT_LSB = 6;
	localparam int OP_LONG_BIT = 9;
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	localparam int STAT_BUSY = 0;
	localparam int STAT_TAKEN = 1;
	localparam int STAT_STACK_ERR = 2;
	localparam int STAT_CYC_LSB = 4;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [9:0] OP_RST = 10'h000;

	// ------------------------------------------------------------
	// Cycle counts
	// ------------------------------------------------------------
	localparam logic [2:0] CYC_PROD = 3'h2;
	localparam logic [2:0] CYC_REL_JUMP = 3'h2;
	localparam logic [2:0] CYC_PTR_JUMP = 3'h2;
	localparam logic [2:0] CYC_ABS_JUMP = 3'h3;
	localparam logic [2:0] CYC_REL_CALL = 3'h3;
	localparam logic [2:0] CYC_PTR_CALL = 3'h3;
	localparam logic [2:0] CYC_ABS_CALL = 3'h4;
	localparam logic [2:0] CYC_RETURN = 3'h4;
	localparam logic [2:0] CYC_SKIP_NONE = 3'h1;
	localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
	localparam logic [2:0] CYC_SKIP_TWO = 3'h3;
	localparam logic [2:0] CYC_CMP = 3'h1;
	localparam logic [2:0] CYC_BR_NOT = 3'h1;
	localparam logic [2:0] CYC_BR_TAKEN = 3'h2;

	typedef enum logic [5:0] {
		OP_UPROD = 6'h00, OP_SPROD = 6'h01, OP_MPROD = 6'h02,
		OP_FUPROD = 6'h03, OP_FSPROD = 6'h04, OP_FMPROD = 6'h05,
		OP_REL_JUMP = 6'h06, OP_PTR_JUMP = 6'h07, OP_ABS_JUMP = 6'h08,
		OP_REL_CALL = 6'h09, OP_PTR_CALL = 6'h0A, OP_ABS_CALL = 6'h0B,
		OP_SUB_EXIT = 6'h0C, OP_INT_EXIT = 6'h0D,
		OP_CMP_SKIP = 6'h0E, OP_CMP = 6'h0F, OP_CMP_CHAIN = 6'h10, OP_CMP_CONST = 6'h11,
		OP_SKIP_RCLR = 6'h12, OP_SKIP_RSET = 6'h13, OP_SKIP_IOCLR = 6'h14,
		OP_SKIP_IOSET = 6'h15,
		OP_BR_FSET = 6'h16, OP_BR_FCLR = 6'h17, OP_BR_EQ = 6'h18, OP_BR_NE = 6'h19,
		OP_BR_CS = 6'h1A, OP_BR_CC = 6'h1B, OP_BR_SH = 6'h1C, OP_BR_LO = 6'h1D,
		OP_BR_MI = 6'h1E, OP_BR_PL = 6'h1F, OP_BR_GE = 6'h20, OP_BR_LT = 6'h21,
		OP_BR_HS = 6'h22, OP_BR_HC = 6'h23, OP_BR_TS = 6'h24, OP_BR_TC = 6'h25,
		OP_BR_VS = 6'h26, OP_BR_VC = 6'h27
	} mpfu_op_t;

	typedef enum logic [1:0] {
		MPFU_IDLE = 2'b01,
		MPFU_EXEC = 2'b10
	} mpfu_state_t;

endpackage

// *** hw/mpfu_stack.sv ***
`timescale 1ns/1ps
module mpfu_stack #(
	parameter int W = 16,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Push and pop
	input wire logic push,
	input wire logic pop,
	input wire logic [W-1:0] push_data,
	// State
	output logic [W-1:0] top_q,
	output logic [$clog2(DEPTH):0] depth_q,
	output logic full,
	output logic empty
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH)
	begin : g_bad_depth
		$error("Stack depth must be a power of two, at least 2");
	end

	logic [W-1:0] mem [DEPTH];
	wire [AW:0] depth_m1 = depth_q - 1'b1;

	assign full = depth_q[AW];
	assign empty = depth_q == '0;

	always_ff @(posedge clk)
	begin
		if (push && !full)
			mem[depth_q[AW-1:0]] <= push_data;
	end

	// Top word is registered; it settles one cycle after a push or pop
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			depth_q <= '0;
			top_q <= '0;
		end
		else
		begin
			top_q <= mem[depth_m1[AW-1:0]];
			if (push && !full)
				depth_q <= depth_q + 1'b1;
			else if (pop && !empty)
				depth_q <= depth_m1;
		end
	end
endmodule

// *** hw/mpfu_core.sv ***
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module mpfu_core #(
	parameter int PC_W = 16,
	parameter int STACK_DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// I/O register under test
	output logic [5:0] io_addr,
	input wire logic [7:0] io_data,
	// Status
	output logic busy
);
	localparam int DW = $clog2(STACK_DEPTH) + 1;
	localparam logic [PC_W-1:0] PC_ONE = 1;
	localparam logic [PC_W-1:0] PC_TWO = 2;
	localparam logic [PC_W-1:0] PC_THREE = 3;

	if (PC_W < 8 || PC_W > 16)
	begin : g_bad_pc
		$error("PC_W must lie between 8 and 16");
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	mpfu_pkg::mpfu_state_t state_q;
	logic ack_q;
	logic [31:0] dat_q;
	logic [9:0] op_q;
	logic [7:0] opa_q, opb_q, flags_q;
	logic [15:0] offs_q, ptrz_q, prod_q;
	logic [PC_W-1:0] pc_q;
	logic [2:0] cnt_q, cyc_q;
	logic taken_q, stack_err_q;
	logic [PC_W-1:0] pc_n_q, push_val_q;
	logic [7:0] flags_n_q;
	logic [15:0] prod_n_q;
	logic prod_wr_q, push_q, pop_q, frac_q;
	logic [PC_W-1:0] top_q;
	logic [DW-1:0] depth_q;
	logic st_full, st_empty;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire idle = state_q == mpfu_pkg::MPFU_IDLE;
	wire bus_req = wb_cyc_i && wb_stb_i && !ack_q;
	wire bus_wr = bus_req && wb_we_i;
	wire [31:0] lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [31:0] stat_word = {25'h0, cyc_q, 1'b0, stack_err_q, taken_q, !idle};
	wire [31:0] rd_mux =
		wb_adr_i == mpfu_pkg::ADDR_OP ? {22'h0, op_q} :
		wb_adr_i == mpfu_pkg::ADDR_OPA ? {24'h0, opa_q} :
		wb_adr_i == mpfu_pkg::ADDR_OPB ? {24'h0, opb_q} :
		wb_adr_i == mpfu_pkg::ADDR_OFFS ? {16'h0, offs_q} :
		wb_adr_i == mpfu_pkg::ADDR_PTRZ ? {16'h0, ptrz_q} :
		wb_adr_i == mpfu_pkg::ADDR_PC ? 32'(pc_q) :
		wb_adr_i == mpfu_pkg::ADDR_FLAGS ? {24'h0, flags_q} :
		wb_adr_i == mpfu_pkg::ADDR_PROD ? {16'h0, prod_q} :
		wb_adr_i == mpfu_pkg::ADDR_STAT ? stat_word :
		wb_adr_i == mpfu_pkg::ADDR_DEPTH ? 32'(depth_q) : 32'h0000_0000;
	wire [31:0] wmerge = (rd_mux & ~lane_mask) | (wb_dat_i & lane_mask);
	wire wr_op = bus_wr && wb_adr_i == mpfu_pkg::ADDR_OP;
	wire wr_opa = bus_wr && wb_adr_i == mpfu_pkg::ADDR_OPA;
	wire wr_opb = bus_wr && wb_adr_i == mpfu_pkg::ADDR_OPB;
	wire wr_offs = bus_wr && wb_adr_i == mpfu_pkg::ADDR_OFFS;
	wire wr_ptrz = bus_wr && wb_adr_i == mpfu_pkg::ADDR_PTRZ;
	// PC and flags belong to the running operation while busy
	wire wr_pc = bus_wr && idle && wb_adr_i == mpfu_pkg::ADDR_PC;
	wire wr_flags = bus_wr && idle && wb_adr_i == mpfu_pkg::ADDR_FLAGS;
	wire clr_err = bus_wr && wb_adr_i == mpfu_pkg::ADDR_STAT && wmerge[mpfu_pkg::STAT_STACK_ERR];
	// Writing the opcode word while busy is dropped
	wire start = wr_op && idle;
	wire done = state_q == mpfu_pkg::MPFU_EXEC && cnt_q == 3'h1;

	// ------------------------------------------------------------
	// Operation decode
	// ------------------------------------------------------------
	wire [9:0] op_d = wmerge[9:0];
	wire [2:0] bsel = op_d[mpfu_pkg::OP_BIT_LSB +: 3];
	wire two_word = op_d[mpfu_pkg::OP_LONG_BIT];
	mpfu_pkg::mpfu_op_t cur_op;
	assign cur_op = mpfu_pkg::mpfu_op_t'(op_d[5:0]);

	wire [15:0] prod_uu = opa_q * opb_q;
	wire signed [15:0] prod_ss = $signed(opa_q) * $signed(opb_q);
	wire signed [16:0] prod_su = $signed(opa_q) * $signed({1'b0, opb_q});

	wire cmp_chain = cur_op == mpfu_pkg::OP_CMP_CHAIN;
	wire [8:0] diff = {1'b0, opa_q} - {1'b0, opb_q} - {8'h00, cmp_chain && flags_q[mpfu_pkg::FLAG_C]};
	wire [7:0] r = diff[7:0];
	wire cmp_z = r == 8'h00;
	wire cmp_v = (opa_q[7] && !opb_q[7] && !r[7]) || (!opa_q[7] && opb_q[7] && r[7]);
	wire cmp_h = (!opa_q[3] && opb_q[3]) || (opb_q[3] && r[3]) || (r[3] && !opa_q[3]);
	wire n_xor_v = flags_q[mpfu_pkg::FLAG_N] ^ flags_q[mpfu_pkg::FLAG_V];

	wire [PC_W-1:0] pc_seq = pc_q + PC_ONE;
	wire [PC_W-1:0] pc_rel = pc_q + offs_q[PC_W-1:0] + PC_ONE;
	wire [PC_W-1:0] pc_skip = two_word ? pc_q + PC_THREE : pc_q + PC_TWO;
	wire [2:0] cyc_skip = two_word ? mpfu_pkg::CYC_SKIP_TWO : mpfu_pkg::CYC_SKIP_ONE;

	logic [2:0] cyc_d;
	logic [PC_W-1:0] pc_d, push_val_d;
	logic [7:0] flags_d;
	logic [15:0] raw_d, prod_d;
	logic prod_wr_d, push_d, pop_d, frac_d, is_br, is_skip, cond;

	always_comb
	begin
		cyc_d = mpfu_pkg::CYC_CMP;
		pc_d = pc_seq;
		flags_d = flags_q;
		raw_d = prod_uu;
		prod_wr_d = 1'b0;
		frac_d = 1'b0;
		push_d = 1'b0;
		pop_d = 1'b0;
		push_val_d = pc_seq;
		is_br = 1'b0;
		is_skip = 1'b0;
		cond = 1'b0;
		unique case (cur_op)
			mpfu_pkg::OP_UPROD, mpfu_pkg::OP_FUPROD:
				raw_d = prod_uu;
			mpfu_pkg::OP_SPROD, mpfu_pkg::OP_FSPROD:
				raw_d = prod_ss;
			mpfu_pkg::OP_MPROD, mpfu_pkg::OP_FMPROD:
				raw_d = prod_su[15:0];
			mpfu_pkg::OP_REL_JUMP:
			begin
				cyc_d = mpfu_pkg::CYC_REL_JUMP;
				pc_d = pc_rel;
			end
			mpfu_pkg::OP_PTR_JUMP:
			begin
				cyc_d = mpfu_pkg::CYC_PTR_JUMP;
				pc_d = ptrz_q[PC_W-1:0];
			end
			mpfu_pkg::OP_ABS_JUMP:
			begin
				cyc_d = mpfu_pkg::CYC_ABS_JUMP;
				pc_d = offs_q[PC_W-1:0];
			end
			mpfu_pkg::OP_REL_CALL:
			begin
				cyc_d = mpfu_pkg::CYC_REL_CALL;
				pc_d = pc_rel;
				push_d = 1'b1;
			end
			mpfu_pkg::OP_PTR_CALL:
			begin
				cyc_d = mpfu_pkg::CYC_PTR_CALL;
				pc_d = ptrz_q[PC_W-1:0];
				push_d = 1'b1;
			end
			mpfu_pkg::OP_ABS_CALL:
			begin
				cyc_d = mpfu_pkg::CYC_ABS_CALL;
				pc_d = offs_q[PC_W-1:0];
				push_d = 1'b1;
				// Two-word call resumes past its address word
				push_val_d = pc_q + PC_TWO;
			end
			mpfu_pkg::OP_SUB_EXIT, mpfu_pkg::OP_INT_EXIT:
			begin
				cyc_d = mpfu_pkg::CYC_RETURN;
				pc_d = top_q;
				pop_d = 1'b1;
				if (cur_op == mpfu_pkg::OP_INT_EXIT)
					flags_d[mpfu_pkg::FLAG_I] = 1'b1;
			end
			mpfu_pkg::OP_CMP_SKIP:
			begin
				is_skip = 1'b1;
				cond = opa_q == opb_q;
			end
			mpfu_pkg::OP_CMP, mpfu_pkg::OP_CMP_CHAIN, mpfu_pkg::OP_CMP_CONST:
			begin
				flags_d[mpfu_pkg::FLAG_Z] = cmp_chain ? cmp_z && flags_q[mpfu_pkg::FLAG_Z] : cmp_z;
				flags_d[mpfu_pkg::FLAG_N] = r[7];
				flags_d[mpfu_pkg::FLAG_V] = cmp_v;
				flags_d[mpfu_pkg::FLAG_C] = diff[8];
				flags_d[mpfu_pkg::FLAG_H] = cmp_h;
			end
			mpfu_pkg::OP_SKIP_RCLR, mpfu_pkg::OP_SKIP_RSET:
			begin
				is_skip = 1'b1;
				cond = opa_q[bsel] == (cur_op == mpfu_pkg::OP_SKIP_RSET);
			end
			mpfu_pkg::OP_SKIP_IOCLR, mpfu_pkg::OP_SKIP_IOSET:
			begin
				is_skip = 1'b1;
				cond = io_data[bsel] == (cur_op == mpfu_pkg::OP_SKIP_IOSET);
			end
			mpfu_pkg::OP_BR_FSET, mpfu_pkg::OP_BR_FCLR:
			begin
				is_br = 1'b1;
				cond = flags_q[bsel] == (cur_op == mpfu_pkg::OP_BR_FSET);
			end
			mpfu_pkg::OP_BR_EQ, mpfu_pkg::OP_BR_NE:
			begin
				is_br = 1'b1;
				cond = flags_q[mpfu_pkg::FLAG_Z] == (cur_op == mpfu_pkg::OP_BR_EQ);
			end
			mpfu_pkg::OP_BR_CS, mpfu_pkg::OP_BR_LO:
			begin
				is_br = 1'b1;
				cond = flags_q[mpfu_pkg::FLAG_C];
			end
			mpfu_pkg::OP_BR_CC, mpfu_pkg::OP_BR_SH:
			begin
				is_br = 1'b1;
				cond = !flags_q[mpfu_pkg::FLAG_C];
			end
			mpfu_pkg::OP_BR_MI, mpfu_pkg::OP_BR_PL:
			begin
				is_br = 1'b1;
				cond = flags_q[mpfu_pkg::FLAG_N] == (cur_op == mpfu_pkg::OP_BR_MI);
			end
			mpfu_pkg::OP_BR_GE, mpfu_pkg::OP_BR_LT:
			begin
				is_br = 1'b1;
				cond = n_xor_v == (cur_op == mpfu_pkg::OP_BR_LT);
			end
			mpfu_pkg::OP_BR_HS, mpfu_pkg::OP_BR_HC:
			begin
				is_br = 1'b1;
				cond = flags_q[mpfu_pkg::FLAG_H] == (cur_op == mpfu_pkg::OP_BR_HS);
			end
			mpfu_pkg::OP_BR_TS, mpfu_pkg::OP_BR_TC:
			begin
				is_br = 1'b1;
				cond = flags_q[mpfu_pkg::FLAG_T] == (cur_op == mpfu_pkg::OP_BR_TS);
			end
			mpfu_pkg::OP_BR_VS, mpfu_pkg::OP_BR_VC:
			begin
				is_br = 1'b1;
				cond = flags_q[mpfu_pkg::FLAG_V] == (cur_op == mpfu_pkg::OP_BR_VS);
			end
			// Unknown codes only step the program counter
			default:
				cyc_d = mpfu_pkg::CYC_CMP;
		endcase
		if (cur_op <= mpfu_pkg::OP_FMPROD)
		begin
			cyc_d = mpfu_pkg::CYC_PROD;
			prod_wr_d = 1'b1;
			frac_d = cur_op >= mpfu_pkg::OP_FUPROD;
		end
		prod_d = frac_d ? {raw_d[14:0], 1'b0} : raw_d;
		if (prod_wr_d)
		begin
			flags_d[mpfu_pkg::FLAG_C] = raw_d[15];
			flags_d[mpfu_pkg::FLAG_Z] = prod_d == 16'h0000;
		end
		if (is_skip)
		begin
			cyc_d = cond ? cyc_skip : mpfu_pkg::CYC_SKIP_NONE;
			pc_d = cond ? pc_skip : pc_seq;
		end
		if (is_br)
		begin
			cyc_d = cond ? mpfu_pkg::CYC_BR_TAKEN : mpfu_pkg::CYC_BR_NOT;
			pc_d = cond ? pc_rel : pc_seq;
		end
	end

	// ------------------------------------------------------------
	// Bus and sequencing registers
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= bus_req;
			dat_q <= bus_req ? rd_mux : dat_q;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_q <= mpfu_pkg::MPFU_IDLE;
			cnt_q <= 3'h0;
		end
		else
		begin
			unique case (state_q)
				mpfu_pkg::MPFU_IDLE:
					if (start)
						state_q <= mpfu_pkg::MPFU_EXEC;
				mpfu_pkg::MPFU_EXEC:
					if (done)
						state_q <= mpfu_pkg::MPFU_IDLE;
			endcase
			cnt_q <= start ? cyc_d : (cnt_q != 3'h0 ? cnt_q - 3'h1 : cnt_q);
		end
	end

	// Results are fixed at the start so operand writes during execution are harmless
	always_ff @(posedge clk)
	begin
		if (start)
		begin
			pc_n_q <= pc_d;
			flags_n_q <= flags_d;
			prod_n_q <= prod_d;
			push_val_q <= push_val_d;
		end
		if (reset)
		begin
			prod_wr_q <= 1'b0;
			push_q <= 1'b0;
			pop_q <= 1'b0;
			frac_q <= 1'b0;
			cyc_q <= 3'h0;
			taken_q <= 1'b0;
		end
		else if (start)
		begin
			cyc_q <= cyc_d;
			taken_q <= (is_br || is_skip) && cond;
			prod_wr_q <= prod_wr_d;
			push_q <= push_d;
			pop_q <= pop_d;
			frac_q <= frac_d;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			op_q <= mpfu_pkg::OP_RST;
			opa_q <= 8'h00;
			opb_q <= 8'h00;
			offs_q <= 16'h0000;
			ptrz_q <= 16'h0000;
			pc_q <= mpfu_pkg::PC_RST[PC_W-1:0];
			flags_q <= mpfu_pkg::FLAGS_RST;
			prod_q <= 16'h0000;
			stack_err_q <= 1'b0;
		end
		else
		begin
			op_q <= start ? op_d : op_q;
			opa_q <= wr_opa ? wmerge[7:0] : opa_q;
			opb_q <= wr_opb ? wmerge[7:0] : opb_q;
			offs_q <= wr_offs ? wmerge[15:0] : offs_q;
			ptrz_q <= wr_ptrz ? wmerge[15:0] : ptrz_q;
			pc_q <= done ? pc_n_q : (wr_pc ? wmerge[PC_W-1:0] : pc_q);
			flags_q <= done ? flags_n_q : (wr_flags ? wmerge[7:0] : flags_q);
			prod_q <= done && prod_wr_q ? prod_n_q : prod_q;
			// A stack fault in the clearing cycle still sticks
			stack_err_q <= (done && ((push_q && st_full) || (pop_q && st_empty)))
				|| (stack_err_q && !clr_err);
		end
	end

	mpfu_stack #(
		.W(PC_W),
		.DEPTH(STACK_DEPTH)
	) u_stack (
		.clk(clk),
		.reset(reset),
		.push(done && push_q),
		.pop(done && pop_q),
		.push_data(push_val_q),
		.top_q(top_q),
		.depth_q(depth_q),
		.full(st_full),
		.empty(st_empty)
	);

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign io_addr = opb_q[5:0];
	assign busy = !idle;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_end1;
		##1 done;
	endsequence
	sequence s_end2;
		##2 done;
	endsequence

	prod_time_a: assert property (start && cur_op <= mpfu_pkg::OP_FMPROD |-> s_end2)
		else $error("product did not finish in two cycles");
	prod_flags_a: assert property (done && prod_wr_q && !frac_q |=>
		flags_q[mpfu_pkg::FLAG_C] == prod_q[15] && flags_q[mpfu_pkg::FLAG_Z] == (prod_q == 16'h0000))
		else $error("integer product flags wrong");
	frac_shift_a: assert property (done && frac_q |=> !prod_q[0] &&
		flags_q[mpfu_pkg::FLAG_Z] == (prod_q == 16'h0000))
		else $error("fractional product not shifted");
	abs_jump_a: assert property (start && cur_op == mpfu_pkg::OP_ABS_JUMP |-> ##3 done)
		else $error("absolute jump length wrong");
	rel_jump_a: assert property (start && cur_op == mpfu_pkg::OP_REL_JUMP |-> s_end2 ##1
		pc_q == $past(pc_q, 3) + offs_q[PC_W-1:0] + PC_ONE)
		else $error("relative jump target wrong");
	call_time_a: assert property (start && cur_op == mpfu_pkg::OP_ABS_CALL |-> ##4 done)
		else $error("absolute call length wrong");
	ret_time_a: assert property (start && cur_op == mpfu_pkg::OP_SUB_EXIT |-> ##4 done)
		else $error("return length wrong");
	skip_long_a: assert property (start && cur_op == mpfu_pkg::OP_CMP_SKIP &&
		opa_q == opb_q && two_word |-> ##3 done ##1 pc_q == $past(pc_q, 4) + PC_THREE)
		else $error("two-word skip wrong");
	cmp_equal_a: assert property (start && cur_op == mpfu_pkg::OP_CMP && opa_q == opb_q |->
		s_end1 ##1 flags_q[mpfu_pkg::FLAG_Z] && !flags_q[mpfu_pkg::FLAG_C])
		else $error("equal compare flags wrong");
	br_not_a: assert property (start && is_br && !cond |-> s_end1 ##1
		pc_q == $past(pc_q, 2) + PC_ONE && $stable(flags_q))
		else $error("untaken branch wrong");
	br_taken_a: assert property (start && cur_op == mpfu_pkg::OP_BR_EQ &&
		flags_q[mpfu_pkg::FLAG_Z] |-> s_end2)
		else $error("taken branch length wrong");
	int_exit_a: assert property (done && op_q[5:0] == mpfu_pkg::OP_INT_EXIT |=>
		flags_q[mpfu_pkg::FLAG_I])
		else $error("interrupt enable not set");
	push_depth_a: assert property (done && push_q && !st_full |=>
		depth_q == $past(depth_q) + 1'b1)
		else $error("call did not push");
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb;
	logic clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, busy;
	logic [7:0] wb_adr_i, io_data;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd_v, last_pc, last_stat;
	logic [5:0] io_addr;
	int err_count = 0;
	int samples_checked = 0;

	mpfu_core uut (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .io_addr(io_addr), .io_data(io_data),
		.busy(busy));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task results;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task check(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// ------------------------------------------------------------
	// Bus and execution helpers
	// ------------------------------------------------------------
	// Ack and read data are taken at the rising edge; one idle cycle follows each request
	task bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		@(posedge clk);
		while (wb_ack_o !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 40)
			check(32'h0, 32'h1, "ack wait");
		rd_v = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk);
	endtask

	task run(input logic [9:0] op);
		int n;
		n = 0;
		bus(1'b1, mpfu_pkg::ADDR_OP, {22'h0, op});
		@(negedge clk);
		while (busy !== 1'b0 && n < 40)
		begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		check({31'h0, busy}, 32'h0, "busy stuck");
		bus(1'b0, mpfu_pkg::ADDR_STAT, 32'h0);
		last_stat = rd_v;
		bus(1'b0, mpfu_pkg::ADDR_PC, 32'h0);
		last_pc = rd_v;
	endtask

	task flow(input logic [9:0] op, input logic [15:0] pc0, input logic [15:0] pce,
		input logic [2:0] cyc);
		bus(1'b1, mpfu_pkg::ADDR_PC, {16'h0, pc0});
		run(op);
		check(last_pc, {16'h0, pce}, "pc");
		check({29'h0, last_stat[6:4]}, {29'h0, cyc}, "cycles");
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_prod;
		logic [16:0] tbl [6];
		tbl = '{17'h1FE01, 17'h00001, 17'h1FF01, 17'h1FC02, 17'h00002, 17'h1FE02};
		bus(1'b0, mpfu_pkg::ADDR_STAT, 32'h0);
		check(rd_v, 32'h0, "status after reset");
		bus(1'b1, mpfu_pkg::ADDR_OPA, 32'hFF);
		bus(1'b1, mpfu_pkg::ADDR_OPB, 32'hFF);
		for (int i = 0; i < 6; i++)
		begin
			flow(10'(i), 16'h10, 16'h11, 3'h2);
			bus(1'b0, mpfu_pkg::ADDR_PROD, 32'h0);
			check(rd_v, {16'h0, tbl[i][15:0]}, "product");
			bus(1'b0, mpfu_pkg::ADDR_FLAGS, 32'h0);
			check({30'h0, rd_v[1:0]}, {30'h0, 1'b0, tbl[i][16]}, "z c");
		end
		bus(1'b1, mpfu_pkg::ADDR_OPA, 32'h00);
		flow(10'h001, 16'h10, 16'h11, 3'h2);
		bus(1'b0, mpfu_pkg::ADDR_FLAGS, 32'h0);
		check({30'h0, rd_v[1:0]}, 32'h2, "zero product flags");
		bus(1'b0, 8'h40, 32'h0);
		check(rd_v, 32'h0, "unmapped");
		$display("products done");
	endtask

	task t_flow;
		bus(1'b1, mpfu_pkg::ADDR_OFFS, 32'h5);
		bus(1'b1, mpfu_pkg::ADDR_PTRZ, 32'h40);
		flow(10'h06, 16'h10, 16'h16, 3'h2);
		flow(10'h07, 16'h10, 16'h40, 3'h2);
		flow(10'h08, 16'h10, 16'h05, 3'h3);
		flow(10'h09, 16'h20, 16'h26, 3'h3);
		flow(10'h0A, 16'h30, 16'h40, 3'h3);
		bus(1'b0, mpfu_pkg::ADDR_DEPTH, 32'h0);
		check(rd_v, 32'h2, "depth");
		flow(10'h0C, 16'h50, 16'h31, 3'h4);
		flow(10'h0B, 16'h60, 16'h05, 3'h4);
		flow(10'h0D, 16'h70, 16'h62, 3'h4);
		bus(1'b0, mpfu_pkg::ADDR_FLAGS, 32'h0);
		check({31'h0, rd_v[7]}, 32'h1, "int enable");
		flow(10'h0C, 16'h70, 16'h21, 3'h4);
		$display("jumps and calls done");
	endtask

	task t_skip;
		bus(1'b1, mpfu_pkg::ADDR_OPA, 32'h04);
		bus(1'b1, mpfu_pkg::ADDR_OPB, 32'h04);
		flow(10'h00E, 16'h10, 16'h12, 3'h2);
		flow(10'h20E, 16'h10, 16'h13, 3'h3);
		flow(10'h093, 16'h10, 16'h12, 3'h2);
		flow(10'h292, 16'h10, 16'h11, 3'h1);
		bus(1'b1, mpfu_pkg::ADDR_OPB, 32'h2A);
		check({26'h0, io_addr}, 32'h2A, "io index");
		io_data <= 8'h08;
		flow(10'h0D5, 16'h10, 16'h12, 3'h2);
		flow(10'h2D5, 16'h10, 16'h13, 3'h3);
		flow(10'h0D4, 16'h10, 16'h11, 3'h1);
		flow(10'h00E, 16'h10, 16'h11, 3'h1);
		bus(1'b1, mpfu_pkg::ADDR_OPA, 32'h00);
		bus(1'b1, mpfu_pkg::ADDR_OPB, 32'h01);
		bus(1'b1, mpfu_pkg::ADDR_FLAGS, 32'h00);
		flow(10'h00F, 16'h10, 16'h11, 3'h1);
		bus(1'b0, mpfu_pkg::ADDR_FLAGS, 32'h0);
		check(rd_v, 32'h25, "compare flags");
		bus(1'b1, mpfu_pkg::ADDR_OPB, 32'h00);
		flow(10'h010, 16'h10, 16'h11, 3'h1);
		bus(1'b0, mpfu_pkg::ADDR_FLAGS, 32'h0);
		check(rd_v, 32'h25, "chained compare flags");
		flow(10'h00F, 16'h10, 16'h11, 3'h1);
		bus(1'b0, mpfu_pkg::ADDR_FLAGS, 32'h0);
		check(rd_v, 32'h02, "equal compare flags");
		bus(1'b1, mpfu_pkg::ADDR_OPA, 32'h10);
		bus(1'b1, mpfu_pkg::ADDR_OPB, 32'h01);
		flow(10'h011, 16'h10, 16'h11, 3'h1);
		bus(1'b0, mpfu_pkg::ADDR_FLAGS, 32'h0);
		check(rd_v, 32'h20, "constant compare flags");
		$display("skips and compares done");
	endtask

	// Branch codes 0x18 to 0x27 against all-clear, all-set and V-only flags; flag-bit branches against H only
	task t_branch;
		logic [7:0] fl [3];
		logic [15:0] mk [3];
		fl = '{8'h00, 8'hFF, 8'h08};
		mk = '{16'hA99A, 16'h5565, 16'h6A9A};
		bus(1'b1, mpfu_pkg::ADDR_OFFS, 32'hFFFD);
		for (int f = 0; f < 3; f++)
			for (int i = 0; i < 16; i++)
			begin
				bus(1'b1, mpfu_pkg::ADDR_FLAGS, {24'h0, fl[f]});
				if (mk[f][i])
					flow(10'h18 + 10'(i), 16'h10, 16'h0E, 3'h2);
				else
					flow(10'h18 + 10'(i), 16'h10, 16'h11, 3'h1);
				bus(1'b0, mpfu_pkg::ADDR_FLAGS, 32'h0);
				check(rd_v, {24'h0, fl[f]}, "flags kept");
			end
		bus(1'b1, mpfu_pkg::ADDR_FLAGS, 32'h20);
		flow(10'h156, 16'h10, 16'h0E, 3'h2);
		flow(10'h157, 16'h10, 16'h11, 3'h1);
		$display("branches done");
	endtask

	initial
	begin
		reset <= 1'b1;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		wb_adr_i <= 8'h00;
		wb_sel_i <= 4'hF;
		wb_dat_i <= 32'h0;
		io_data <= 8'h00;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_prod();
		t_flow();
		t_skip();
		t_branch();
		results();
	end

	// Roughly 80 operations of under 40 cycles each
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		results();
	end
endmodule
